// ===== hw/tcc_consts.vh
`ifndef TCC_CONSTS_VH
`define TCC_CONSTS_VH

// register map, block numbers (address bits 7:4) and byte addresses
`define TCC_BLK_CFG     4'h0
`define TCC_BLK_STAT    4'h1
`define TCC_BLK_DATA    4'h2
`define TCC_OFF_IRQ_ST  8'h30
`define TCC_OFF_IRQ_MSK 8'h34
`define TCC_OFF_MOD_ST  8'h38

// configuration and status word fields
`define TCC_TYPE_LSB    0
`define TCC_FMT_LSB     4
`define TCC_OC_LSB      6
`define TCC_UNITS_BIT   8
`define TCC_FILT_LSB    9
`define TCC_EN_BIT      11
`define TCC_OPEN_BIT    12
`define TCC_UNDER_BIT   13
`define TCC_OVER_BIT    14
`define TCC_CERR_BIT    15

// encodings
`define TCC_TYPE_BAD_LO 4'hc
`define TCC_TYPE_BAD_HI 4'he
`define TCC_OC_ZERO     2'b00
`define TCC_OC_UP       2'b01
`define TCC_OC_DOWN     2'b10
`define TCC_OC_BAD      2'b11
`define TCC_DATA_UP     16'h7fff
`define TCC_DATA_DOWN   16'h8000

// interrupt status layout
`define TCC_IRQ_RDY_LSB  0
`define TCC_IRQ_OPEN_LSB 4
`define TCC_IRQ_CJ_BIT   8

// reset values
`define TCC_CFG_RST     16'h0000
`define TCC_DATA_RST    16'h0000
`define TCC_MSK_RST     9'h000

// timing
`define TCC_CLK_NS      50
`define TCC_SLOT_NS     100000
`define TCC_SLOT_CYC    ((`TCC_SLOT_NS + `TCC_CLK_NS - 1) / `TCC_CLK_NS)
`define TCC_RCFG_UPD    4'h2
`define TCC_CAL_UPD     4'h6
`define TCC_BLINK_SLOTS 12'd2500

`endif

// ===== hw/tcc_chan.v
`timescale 1ns/1ps
`include "tcc_consts.vh"

module tcc_chan (
  input  wire        i_clk,
  input  wire        i_rst_n,
  input  wire [15:0] i_cfg,
  input  wire        i_upd,
  input  wire        i_susp,
  input  wire        i_conv_valid,
  input  wire [15:0] i_conv_data,
  input  wire        i_conv_under,
  input  wire        i_conv_over,
  input  wire        i_open,
  output reg  [15:0] o_status,
  output reg  [15:0] o_data,
  output wire        o_cfg_busy,
  output wire        o_cal,
  output wire        o_want,
  output reg         o_rdy_evt,
  output reg         o_open_evt
);

  localparam S_OFF = 3'd0;
  localparam S_CFG = 3'd1;
  localparam S_CAL = 3'd2;
  localparam S_SMP = 3'd3;
  localparam S_RUN = 3'd4;

  reg [2:0]  state;
  reg [15:0] applied;
  reg        need_cal;
  reg [3:0]  cnt;
  reg        open_flag;
  reg        under;
  reg        over;
  reg [15:0] oc_val;

  wire       en      = i_cfg[`TCC_EN_BIT];
  wire       chg     = (i_cfg != applied);
  wire       cal_chg = (i_cfg[3:0] != applied[3:0]) |
                       (i_cfg[10:9] != applied[10:9]);
  wire       take    = i_conv_valid & ~i_susp &
                       ((state == S_SMP) | (state == S_RUN));
  wire [3:0] ityp    = applied[3:0];
  wire       cerr    = ((ityp >= `TCC_TYPE_BAD_LO) &&
                        (ityp <= `TCC_TYPE_BAD_HI)) |
                       (applied[7:6] == `TCC_OC_BAD);

  assign o_cfg_busy = (state == S_CFG);
  assign o_cal      = (state == S_CAL);
  assign o_want     = (state == S_SMP) | (state == S_RUN);

  always @* begin
    case (applied[7:6])
      `TCC_OC_UP:   oc_val = `TCC_DATA_UP;
      `TCC_OC_DOWN: oc_val = `TCC_DATA_DOWN;
      default:      oc_val = 16'h0000;
    endcase
  end

  // disabled channel status reads all zero, data keeps its last value
  always @* begin
    if (state == S_OFF) begin
      o_status = 16'h0000;
    end else begin
      o_status = {cerr, over, under, open_flag, (state == S_RUN),
                  applied[10:0]};
    end
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state      <= S_OFF;
      applied    <= `TCC_CFG_RST;
      need_cal   <= 1'b0;
      cnt        <= 4'h0;
      open_flag  <= 1'b0;
      under      <= 1'b0;
      over       <= 1'b0;
      o_data     <= `TCC_DATA_RST;
      o_rdy_evt  <= 1'b0;
      o_open_evt <= 1'b0;
    end else begin
      o_rdy_evt  <= 1'b0;
      o_open_evt <= 1'b0;
      if (!en) begin
        state     <= S_OFF;
        applied   <= `TCC_CFG_RST;
        open_flag <= 1'b0;
        under     <= 1'b0;
        over      <= 1'b0;
        cnt       <= 4'h0;
      end else begin
        if ((state == S_OFF) || chg) begin
          state    <= S_CFG;
          cnt      <= 4'h0;
          applied  <= i_cfg;
          need_cal <= (state == S_OFF) | (state == S_CAL) |
                      ((state == S_CFG) & need_cal) | cal_chg;
        end else begin
          case (state)
            S_CFG: begin
              if (i_upd) begin
                if (cnt == `TCC_RCFG_UPD - 4'h1) begin
                  state <= need_cal ? S_CAL : S_SMP;
                  cnt   <= 4'h0;
                end else begin
                  cnt <= cnt + 4'h1;
                end
              end
            end
            S_CAL: begin
              if (i_upd) begin
                if (cnt == `TCC_CAL_UPD - 4'h1) begin
                  state    <= S_SMP;
                  need_cal <= 1'b0;
                  cnt      <= 4'h0;
                end else begin
                  cnt <= cnt + 4'h1;
                end
              end
            end
            default: begin
              if (take) begin
                o_data <= open_flag ? oc_val : i_conv_data;
                under  <= i_conv_under;
                over   <= i_conv_over;
                if (state == S_SMP) begin
                  state     <= S_RUN;
                  o_rdy_evt <= 1'b1;
                end
              end
            end
          endcase
        end
        if ((state != S_OFF) && !i_susp) begin
          open_flag <= i_open;
          if (i_open && !open_flag) begin
            o_open_evt <= 1'b1;
          end
        end
      end
    end
  end

endmodule // tcc_chan

// ===== hw/tcc_top.v
`timescale 1ns/1ps
`include "tcc_consts.vh"

module tcc_top (
  input  wire        I_REF_CLK,
  input  wire        I_NRST,
  input  wire        I_PSEL,
  input  wire        I_PENABLE,
  input  wire        I_PWRITE,
  input  wire [7:0]  I_PADDR,
  input  wire [31:0] I_PWDATA,
  output reg  [31:0] O_PRDATA,
  output reg         O_PREADY,
  output reg         O_PSLVERR,
  input  wire [3:0]  I_OPEN_WIRE,
  input  wire        I_COLD_JUNCTION_FAULT,
  input  wire        I_CONV_VALID,
  input  wire [15:0] I_CONV_DATA,
  input  wire        I_CONV_UNDER,
  input  wire        I_CONV_OVER,
  output reg         O_CONV_REQ,
  output reg  [1:0]  O_CONV_CH,
  output reg  [3:0]  O_CONV_TYPE,
  output reg  [1:0]  O_CONV_FILT,
  output reg  [3:0]  O_CAL_ACTIVE,
  output reg  [3:0]  O_CH_LED,
  output reg         O_IRQ
);

  // configuration words, one per channel
  reg  [63:0] cfg;

  // per channel results
  wire [63:0] status;
  wire [63:0] data;
  wire [3:0]  cfg_busy;
  wire [3:0]  cal;
  wire [3:0]  want;
  wire [3:0]  rdy_evt;
  wire [3:0]  open_evt;
  wire [3:0]  upd;
  wire [3:0]  conv_valid_ch;
  wire [3:0]  open_in;
  wire        susp;

  // pin synchronisers
  reg  [3:0]  ow_s1;
  reg  [3:0]  ow_s2;
  reg         cj_s1;
  reg         cj_s2;
  reg         cj_q;

  // scan timing
  reg  [11:0] slot_cnt;
  reg  [1:0]  scan_ch;
  reg         tick;
  reg  [11:0] blink_cnt;
  reg         blink;

  // interrupt block
  reg  [8:0]  irq_st;
  reg  [8:0]  irq_msk;
  wire [8:0]  irq_set;
  reg  [8:0]  irq_clr;
  reg  [8:0]  next_irq_st;

  // apb
  wire        apb_acc;
  wire        apb_done;
  wire        apb_wr;
  wire        apb_rd;
  wire [1:0]  a_ch;
  wire        a_cfg;
  wire        a_stat;
  wire        a_data;
  wire        a_irq_st;
  wire        a_irq_msk;
  wire        a_mod_st;
  wire        a_hit;
  reg  [31:0] next_prdata;
  reg         next_pslverr;

  // per channel led decision
  reg  [3:0]  next_led;
  reg  [15:0] st_w;
  integer     k;

  assign susp = |cfg_busy;

  // cold junction fault counts as open on every channel
  assign open_in = ow_s2 | {4{cj_s2}};

  assign upd = tick ? (4'b0001 << scan_ch) : 4'b0000;

  assign conv_valid_ch = I_CONV_VALID ? (4'b0001 << O_CONV_CH) : 4'b0000;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_ch
      tcc_chan u_chan (
        .i_clk        (I_REF_CLK),
        .i_rst_n      (I_NRST),
        .i_cfg        (cfg[g*16 +: 16]),
        .i_upd        (upd[g]),
        .i_susp       (susp),
        .i_conv_valid (conv_valid_ch[g]),
        .i_conv_data  (I_CONV_DATA),
        .i_conv_under (I_CONV_UNDER),
        .i_conv_over  (I_CONV_OVER),
        .i_open       (open_in[g]),
        .o_status     (status[g*16 +: 16]),
        .o_data       (data[g*16 +: 16]),
        .o_cfg_busy   (cfg_busy[g]),
        .o_cal        (cal[g]),
        .o_want       (want[g]),
        .o_rdy_evt    (rdy_evt[g]),
        .o_open_evt   (open_evt[g])
      );
    end
  endgenerate

  // two flops on the open wire and cold junction pins
  always @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      ow_s1 <= 4'h0;
      ow_s2 <= 4'h0;
      cj_s1 <= 1'b0;
      cj_s2 <= 1'b0;
      cj_q  <= 1'b0;
    end else begin
      ow_s1 <= I_OPEN_WIRE;
      ow_s2 <= ow_s1;
      cj_s1 <= I_COLD_JUNCTION_FAULT;
      cj_s2 <= cj_s1;
      cj_q  <= cj_s2;
    end
  end

  // channel update slots, one channel per slot
  always @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      slot_cnt <= 12'h000;
      scan_ch  <= 2'h0;
      tick     <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (slot_cnt == `TCC_SLOT_CYC - 1) begin
        slot_cnt <= 12'h000;
        tick     <= 1'b1;
      end else begin
        slot_cnt <= slot_cnt + 12'h001;
      end
      if (tick) begin
        scan_ch <= scan_ch + 2'h1;
      end
    end
  end

  // conversion request, never during reconfig or to a calibrating channel
  always @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_CONV_REQ  <= 1'b0;
      O_CONV_CH   <= 2'h0;
      O_CONV_TYPE <= 4'h0;
      O_CONV_FILT <= 2'h0;
    end else begin
      O_CONV_REQ <= 1'b0;
      if (tick && want[scan_ch] && !susp) begin
        O_CONV_REQ  <= 1'b1;
        O_CONV_CH   <= scan_ch;
        O_CONV_TYPE <= cfg[scan_ch*16 + `TCC_TYPE_LSB +: 4];
        O_CONV_FILT <= cfg[scan_ch*16 + `TCC_FILT_LSB +: 2];
      end
    end
  end

  // led blink base
  always @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      blink_cnt <= 12'h000;
      blink     <= 1'b0;
    end else if (tick) begin
      if (blink_cnt == `TCC_BLINK_SLOTS - 12'd1) begin
        blink_cnt <= 12'h000;
        blink     <= ~blink;
      end else begin
        blink_cnt <= blink_cnt + 12'h001;
      end
    end
  end

  // faulted channel blinks, ready channel steady
  always @* begin
    next_led = 4'h0;
    st_w     = 16'h0000;
    for (k = 0; k < 4; k = k + 1) begin
      st_w = status[k*16 +: 16];
      if (|st_w[15:12]) begin
        next_led[k] = blink;
      end else begin
        next_led[k] = st_w[`TCC_EN_BIT];
      end
    end
  end

  always @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_CH_LED     <= 4'h0;
      O_CAL_ACTIVE <= 4'h0;
    end else begin
      O_CH_LED     <= next_led;
      O_CAL_ACTIVE <= cal;
    end
  end

  // apb decode
  assign apb_acc   = I_PSEL & I_PENABLE;
  assign apb_done  = apb_acc & O_PREADY;
  assign apb_wr    = apb_done & I_PWRITE;
  assign apb_rd    = apb_done & ~I_PWRITE;
  assign a_ch      = I_PADDR[3:2];
  assign a_cfg     = (I_PADDR[7:4] == `TCC_BLK_CFG) &
                     (I_PADDR[1:0] == 2'b00);
  assign a_stat    = (I_PADDR[7:4] == `TCC_BLK_STAT) &
                     (I_PADDR[1:0] == 2'b00);
  assign a_data    = (I_PADDR[7:4] == `TCC_BLK_DATA) &
                     (I_PADDR[1:0] == 2'b00);
  assign a_irq_st  = (I_PADDR == `TCC_OFF_IRQ_ST);
  assign a_irq_msk = (I_PADDR == `TCC_OFF_IRQ_MSK);
  assign a_mod_st  = (I_PADDR == `TCC_OFF_MOD_ST);
  assign a_hit     = a_cfg | a_stat | a_data | a_irq_st |
                     a_irq_msk | a_mod_st;

  always @* begin
    next_prdata  = 32'h0000_0000;
    next_pslverr = ~a_hit;
    if (a_cfg) begin
      next_prdata = {16'h0000, cfg[a_ch*16 +: 16]};
    end else if (a_stat) begin
      next_prdata = {16'h0000, status[a_ch*16 +: 16]};
    end else if (a_data) begin
      next_prdata = {16'h0000, data[a_ch*16 +: 16]};
    end else if (a_irq_st) begin
      next_prdata = {23'h000000, irq_st};
    end else if (a_irq_msk) begin
      next_prdata = {23'h000000, irq_msk};
    end else if (a_mod_st) begin
      next_prdata = {24'h000000, cal, 2'b00, susp, cj_s2};
    end
  end

  // one wait state, answer registered
  always @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_PREADY  <= 1'b0;
      O_PRDATA  <= 32'h0000_0000;
      O_PSLVERR <= 1'b0;
    end else begin
      O_PREADY  <= apb_acc & ~O_PREADY;
      O_PSLVERR <= apb_acc & ~O_PREADY & next_pslverr;
      if (apb_acc && !O_PREADY && !I_PWRITE) begin
        O_PRDATA <= next_prdata;
      end else begin
        O_PRDATA <= 32'h0000_0000;
      end
    end
  end

  // config and mask writes; each channel word independent
  always @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      cfg     <= {4{`TCC_CFG_RST}};
      irq_msk <= `TCC_MSK_RST;
    end else begin
      if (apb_wr && a_cfg) begin
        cfg[a_ch*16 +: 16] <= I_PWDATA[15:0];
      end
      if (apb_wr && a_irq_msk) begin
        irq_msk <= I_PWDATA[8:0];
      end
    end
  end

  // sticky events, read clears, new event wins
  assign irq_set = {cj_s2 & ~cj_q, open_evt, rdy_evt};

  always @* begin
    irq_clr     = (apb_rd && a_irq_st) ? irq_st : 9'h000;
    next_irq_st = (irq_st & ~irq_clr) | irq_set;
  end

  always @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      irq_st <= 9'h000;
      O_IRQ  <= 1'b0;
    end else begin
      irq_st <= next_irq_st;
      O_IRQ  <= |(next_irq_st & irq_msk);
    end
  end

endmodule // tcc_top

// ===== dv/tcc_monitor.sv
`timescale 1ns/1ps
module tcc_monitor (
  input wire logic        I_REF_CLK,
  input wire logic        I_NRST,
  input wire logic        I_PSEL,
  input wire logic        I_PENABLE,
  input wire logic [31:0] O_PRDATA,
  input wire logic        O_PREADY,
  input wire logic        O_PSLVERR,
  input wire logic        O_CONV_REQ,
  input wire logic [1:0]  O_CONV_CH,
  input wire logic [3:0]  O_CONV_TYPE,
  input wire logic [1:0]  O_CONV_FILT,
  input wire logic [3:0]  O_CAL_ACTIVE
);
  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (!I_NRST);

  AST_PREADY_WAIT: assert property (
    I_PSEL && !I_PENABLE |=> !O_PREADY ##1 O_PREADY)
    else $error("ready not after one wait state");
  AST_PREADY_ONE: assert property (O_PREADY |=> !O_PREADY)
    else $error("ready held too long");
  AST_SLVERR_READY: assert property (
    O_PSLVERR |-> O_PREADY && O_PRDATA == 32'h0)
    else $error("bad error response");
  AST_PRDATA_IDLE: assert property (!O_PREADY |-> O_PRDATA == 32'h0)
    else $error("read data outside ready");
  AST_REQ_SPACING: assert property (O_CONV_REQ |=> !O_CONV_REQ [*8])
    else $error("requests too close");
  AST_REQ_NOT_CAL: assert property (
    O_CONV_REQ |-> !O_CAL_ACTIVE[O_CONV_CH])
    else $error("request to calibrating channel");
  AST_CONV_HOLD: assert property (
    !O_CONV_REQ |-> $stable({O_CONV_CH, O_CONV_TYPE, O_CONV_FILT}))
    else $error("selection changed without request");
  AST_CAL_SPAN: assert property (
    $rose(O_CAL_ACTIVE[0]) |=> O_CAL_ACTIVE[0] [*8])
    else $error("calibration too short");
  cover property (O_PSLVERR);
  cover property ($rose(O_CAL_ACTIVE[0]));
  cover property (O_CONV_REQ ##1 !O_CONV_REQ);
endmodule // tcc_monitor

// ===== dv/tcc_conv_model.sv
`timescale 1ns/1ps
module tcc_conv_model (
  input  wire logic       i_clk,
  input  wire logic       i_req,
  input  wire logic [1:0] i_ch,
  input  wire logic       i_slow,
  output logic            o_valid,
  output logic [15:0]     o_data
);
  initial begin
    o_valid = 1'b0;
    o_data  = 16'h0;
  end
  // idle data toggles so no stale result looks valid
  always @(posedge i_clk) begin
    o_valid <= 1'b0;
    o_data  <= ~o_data;
    if (i_req) begin
      repeat (i_slow ? 7 : 1) @(posedge i_clk);
      o_valid <= 1'b1;
      o_data  <= 16'h1230 | 16'(i_ch);
    end
  end
endmodule // tcc_conv_model

// ===== dv/test_thermocouple_channel_config_control.sv
`timescale 1ns/1ps
module test_thermocouple_channel_config_control;
  logic        clk, rst_n, psel, pen, pwr, cj, cv, slow, err;
  logic        pready, pslverr, creq, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  open_w, ctype, cal, led;
  logic [1:0]  cch, cfilt;
  logic [15:0] cdata;
  logic [15:0] cfg [4];
  int          num_errors, n_compared, seed, i, n;

  tcc_top DUT (
    .I_REF_CLK(clk), .I_NRST(rst_n), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_OPEN_WIRE(open_w),
    .I_COLD_JUNCTION_FAULT(cj), .I_CONV_VALID(cv), .I_CONV_DATA(cdata),
    .I_CONV_UNDER(1'b0), .I_CONV_OVER(1'b0), .O_CONV_REQ(creq),
    .O_CONV_CH(cch), .O_CONV_TYPE(ctype), .O_CONV_FILT(cfilt),
    .O_CAL_ACTIVE(cal), .O_CH_LED(led), .O_IRQ(irq)
  );
  tcc_conv_model u_conv (
    .i_clk(clk), .i_req(creq), .i_ch(cch), .i_slow(slow),
    .o_valid(cv), .o_data(cdata)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic give_verdict();
    $display("compared %0d mismatched %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (pready !== 1'b1) begin
      num_errors++;
      give_verdict();
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, string s);
    apb(1'b0, a, 32'h0);
    check(s, rd, e);
  endtask

  task automatic poll(input logic [7:0] a, input logic [31:0] m, v);
    int k;
    k = 0;
    do begin
      apb(1'b0, a, 32'h0);
      slow <= 1'($random(seed));
      k++;
    end while ((rd & m) !== v && k < 25000);
    check("poll", rd & m, v);
    if ((rd & m) !== v)
      give_verdict();
  endtask

  function automatic logic [15:0] mk_cfg();
    logic [3:0] t;
    logic [1:0] oc;
    t = 4'($unsigned($random(seed)) % 12);
    oc = 2'($unsigned($random(seed)) % 3);
    return {5'h01, 3'($random(seed)), oc, 2'($random(seed)), t};
  endfunction

  function automatic logic [31:0] exp_stat(input logic [15:0] c, logic op);
    return c[11] ? {19'h0, op, c[11:0]} : 32'h0;
  endfunction

  initial begin
    seed = 32'he6760c0d;
    num_errors = 0;
    n_compared = 0;
    rst_n = 1'b0;
    {psel, pen, pwr, cj, slow} = 5'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    open_w = 4'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 4; i++) begin
      rdchk(8'(i * 4), 32'h0, "cfg");
      rdchk(8'(i * 4 + 8'h10), 32'h0, "status");
    end
    rdchk(8'h34, 32'h0, "mask");
    apb(1'b0, 8'h3c, 32'h0);
    check("unmapped", err, 1'b1);
    apb(1'b1, 8'h02, 32'hffff);
    check("misaligned", err, 1'b1);
    rdchk(8'h00, 32'h0, "ignored write");
    $display("register test done");
    for (i = 0; i < 4; i++) begin
      cfg[i] = mk_cfg();
      apb(1'b1, 8'(i * 4), {16'h0, cfg[i] & 16'hf7ff});
      apb(1'b1, 8'(i * 4), {16'h0, cfg[i]});
    end
    apb(1'b0, 8'h10, 32'h0);
    check("early ready", rd[11], 1'b0);
    n = 0;
    while (cal[0] !== 1'b1 && n < 40000) begin
      @(posedge clk);
      n++;
    end
    check("cal", cal[0], 1'b1);
    if (cal[0] !== 1'b1)
      give_verdict();
    apb(1'b0, 8'h10, 32'h0);
    check("ready in cal", rd[11], 1'b0);
    for (i = 0; i < 4; i++) begin
      poll(8'(i * 4 + 8'h10), 32'h800, 32'h800);
      rdchk(8'(i * 4 + 8'h10), exp_stat(cfg[i], 1'b0), "st");
      rdchk(8'(i * 4 + 8'h20), 32'h1230 + i, "data");
    end
    repeat (2) @(posedge clk);
    check("ready led", led, 4'hf);
    check("irq masked", irq, 1'b0);
    apb(1'b1, 8'h34, 32'h1ff);
    repeat (2) @(posedge clk);
    check("irq", irq, 1'b1);
    rdchk(8'h30, 32'h00f, "irq status");
    repeat (2) @(posedge clk);
    check("irq clear", irq, 1'b0);
    $display("enable test done");
    cfg[0] = cfg[0] ^ 16'h0100;
    apb(1'b1, 8'h00, {16'h0, cfg[0]});
    open_w <= 4'h2;
    rdchk(8'h38, 32'h2, "busy");
    apb(1'b0, 8'h10, 32'h0);
    check("reconf st", rd[11:8], {1'b0, cfg[0][10:8]});
    repeat (8) @(posedge clk);
    apb(1'b0, 8'h14, 32'h0);
    check("open frozen", rd[12], 1'b0);
    poll(8'h10, 32'h900, {16'h0, cfg[0] & 16'h0900});
    poll(8'h14, 32'h1000, 32'h1000);
    rdchk(8'h14, exp_stat(cfg[1], 1'b1), "open st");
    cj <= 1'b1;
    poll(8'h1c, 32'h1000, 32'h1000);
    for (i = 0; i < 4; i++) begin
      apb(1'b0, 8'(i * 4 + 8'h10), 32'h0);
      check("cj open", rd[12], 1'b1);
    end
    check("cj led", led, 4'h0);
    apb(1'b0, 8'h30, 32'h0);
    check("cj irq", rd[8], 1'b1);
    $display("open test done");
    cj <= 1'b0;
    apb(1'b1, 8'h0c, {16'h0, cfg[3] & 16'hf7ff});
    poll(8'h1c, 32'h800, 32'h0);
    rdchk(8'h1c, 32'h0, "disabled");
    apb(1'b1, 8'h0c, {16'h0, cfg[3]});
    rdchk(8'h38, 32'h2, "re-enable");
    $display("recalibration test done");
    give_verdict();
  end
endmodule // test_thermocouple_channel_config_control

bind tcc_top tcc_monitor u_mon (
  .I_REF_CLK(I_REF_CLK), .I_NRST(I_NRST), .I_PSEL(I_PSEL),
  .I_PENABLE(I_PENABLE), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY),
  .O_PSLVERR(O_PSLVERR), .O_CONV_REQ(O_CONV_REQ), .O_CONV_CH(O_CONV_CH),
  .O_CONV_TYPE(O_CONV_TYPE), .O_CONV_FILT(O_CONV_FILT),
  .O_CAL_ACTIVE(O_CAL_ACTIVE)
);
